/* logic/sbcsa_top.sv */
// Purpose: Control, shift and own-address logic of a two-line serial bus
// Assumes: Serial clock comes from the bus master; pins are asynchronous
// Notes: Bus lines are open-drain, only ever pulled low by this block
//
// Design decisions made here: register access over Avalon-MM and the placing of the registers.

`timescale 1ns/1ps

// What this block does
// - Release trigger write sets the output latch; trigger reads back zero.
// - Command trigger write clears the output latch; trigger reads back zero.
// - Release flag sets on release; clears on start, disable, address miss.
// - Command flag sets on command; clears on start, release, disable.
// - Ack trigger after transfer drives ack on next clock, then clears.
// - Software cannot clear the ack trigger; only sent ack clears it.
// - Auto ack off gives no ack; on gives ack on ninth clock.
// - Auto ack enabled after transfer drives ack on the next clock.
// - Ack flag sets on low ack at rising clock; clears on start.
// - Busy enable drives busy after ack from a falling clock edge.
// - Clearing busy enable stops busy at the next falling clock edge.
// - Eight-bit shift register moves with serial clock; write starts transfer.
// - Transmit on output or bus line; receive from input or bus line.
// - Shifting stops after eight bits.
// - Shift register content is not touched by reset.
// - Own address register is write-only and not touched by reset.
// - Received byte compared with own address sets the match flag.
// - Release is data rising while clock high; next byte is address.
// - Command is data falling while clock high.
// - With wake on, done flag rises only on matching address.
// - With wake off, done flag rises on every ninth rising clock.
module sbcsa_top (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Serial pins
  input wire logic serial_clock_line_i,
  input wire logic serial_input_line_i,
  output logic serial_output_line_o,
  input wire logic bus_data_line_a_i,
  output logic bus_data_line_a_o,
  output logic bus_data_line_a_oe_o,
  input wire logic bus_data_line_b_i,
  output logic bus_data_line_b_o,
  output logic bus_data_line_b_oe_o
);

  // ==========================================================
  // Reset release and input synchronisers
  logic [1:0] rst_q;
  logic rstn;
  logic [2:0] scl_q;
  logic [2:0] da_q;
  logic [2:0] db_q;
  logic [1:0] si_q;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rstn = rst_q[1];

  always_ff @(posedge ref_clk_i or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 3'h7;
      da_q <= 3'h7;
      db_q <= 3'h7;
      si_q <= 2'h3;
    end else begin
      scl_q <= {scl_q[1:0], serial_clock_line_i};
      da_q <= {da_q[1:0], bus_data_line_a_i};
      db_q <= {db_q[1:0], bus_data_line_b_i};
      si_q <= {si_q[0], serial_input_line_i};
    end
  end

  // ==========================================================
  // State
  sbcsa_pkg::sbcsa_flags_t fl, next_fl;
  sbcsa_pkg::sbcsa_mode_t md, next_md;
  sbcsa_pkg::sbcsa_phase_t ph, next_ph;
  sbcsa_pkg::sbcsa_wr_t wr;
  logic [3:0] cnt, next_cnt;
  logic so, next_so;
  logic ack_drv, next_ack_drv;
  logic ack_sent, next_ack_sent;
  logic busy_drv, next_busy_drv;
  logic irq, next_irq;
  logic oe_a, next_oe_a;
  logic oe_b, next_oe_b;
  logic [7:0] sh, next_sh;
  logic [7:0] own_addr, next_own_addr;
  logic wait_q, next_wait_q;
  logic [31:0] rdata, next_rdata;

  logic rise, fall, sda, sda_d, rx_bit;
  logic rel_cond, cmd_cond, start, byte_done, ninth, ack_end;
  logic match;

  // Edges come from the second and third stages only
  assign rise = scl_q[1] & ~scl_q[2];
  assign fall = ~scl_q[1] & scl_q[2];
  assign sda = md.line_b ? db_q[1] : da_q[1];
  assign sda_d = md.line_b ? db_q[2] : da_q[2];
  assign rx_bit = md.three_wire ? si_q[1] : sda;
  assign rel_cond = md.serial_enable & ~md.three_wire & scl_q[1] &
                    scl_q[2] & sda & ~sda_d;
  assign cmd_cond = md.serial_enable & ~md.three_wire & scl_q[1] &
                    scl_q[2] & ~sda & sda_d;

  // ==========================================================
  // Avalon slave: one wait cycle, then the answer
  always_comb begin
    next_wait_q = 1'b1;
    next_rdata = rdata;
    wr.valid = avs_write_i & ~wait_q & avs_byteenable_i[0];
    wr.addr = avs_address_i;
    wr.data = avs_writedata_i[7:0];
    if ((avs_read_i | avs_write_i) & wait_q) begin
      next_wait_q = 1'b0;
      next_rdata = 32'h0;
      if (avs_read_i) begin
        if (avs_address_i == sbcsa_pkg::OFS_CTRL) begin
          next_rdata[sbcsa_pkg::POS_RELEASE_DET] = fl.release_detected;
          next_rdata[sbcsa_pkg::POS_COMMAND_DET] = fl.command_detected;
          next_rdata[sbcsa_pkg::POS_ACK_AUTO] = fl.ack_auto_enable;
          next_rdata[sbcsa_pkg::POS_ACK_DET] = fl.ack_detected;
          next_rdata[sbcsa_pkg::POS_BUSY_EN] = fl.busy_signal_enable;
        end else if (avs_address_i == sbcsa_pkg::OFS_SHIFT) begin
          next_rdata[7:0] = sh;
        end else if (avs_address_i == sbcsa_pkg::OFS_MODE) begin
          next_rdata[sbcsa_pkg::POS_SER_EN] = md.serial_enable;
          next_rdata[sbcsa_pkg::POS_MATCH] = md.address_match_flag;
          next_rdata[sbcsa_pkg::POS_WAKE] = md.wake_on_address;
          next_rdata[sbcsa_pkg::POS_THREE_WIRE] = md.three_wire;
          next_rdata[sbcsa_pkg::POS_LINE_B] = md.line_b;
        end else if (avs_address_i == sbcsa_pkg::OFS_STAT) begin
          next_rdata[sbcsa_pkg::POS_IRQ] = irq;
          next_rdata[sbcsa_pkg::POS_ACTIVE] =
            (ph == sbcsa_pkg::PH_SHIFT) | (ph == sbcsa_pkg::PH_ACK9);
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 1'b1;
      rdata <= 32'h0;
    end else begin
      wait_q <= next_wait_q;
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Serial core
  always_comb begin
    next_fl = fl;
    next_md = md;
    next_ph = ph;
    next_cnt = cnt;
    next_so = so;
    next_ack_drv = ack_drv;
    next_ack_sent = ack_sent;
    next_busy_drv = busy_drv;
    next_irq = irq;
    next_sh = sh;
    next_own_addr = own_addr;
    byte_done = 1'b0;
    ninth = 1'b0;
    ack_end = 1'b0;
    start = 1'b0;
    match = 1'b0;
    if (!md.serial_enable) begin
      next_ph = sbcsa_pkg::PH_IDLE;
      next_cnt = 4'h0;
    end else begin
      case (ph)
        sbcsa_pkg::PH_SHIFT: begin
          if (fall) begin
            next_so = sh[7];
          end
          if (rise) begin
            next_sh = {sh[6:0], rx_bit};
            next_cnt = cnt + 4'h1;
            if (cnt == sbcsa_pkg::LAST_BIT) begin
              next_ph = sbcsa_pkg::PH_ACK9;
              byte_done = 1'b1;
            end
          end
        end
        sbcsa_pkg::PH_ACK9: begin
          if (fall) begin
            next_so = 1'b1;
            next_ack_drv = fl.ack_auto_enable;
          end
          if (rise) begin
            next_ph = sbcsa_pkg::PH_DONE;
            ninth = 1'b1;
          end
        end
        sbcsa_pkg::PH_DONE: begin
          if (fall) begin
            if (ack_drv) begin
              next_ack_drv = 1'b0;
              next_ack_sent = 1'b1;
              ack_end = 1'b1;
              next_busy_drv = fl.busy_signal_enable;
            end else if (!ack_sent &&
                         (fl.ack_trigger || fl.ack_auto_enable)) begin
              next_ack_drv = 1'b1;
            end else begin
              next_busy_drv = fl.busy_signal_enable;
            end
          end
        end
        default: begin
        end
      endcase
    end

    if (byte_done) begin
      match = (next_sh == own_addr);
      next_md.address_match_flag = match;
    end

    // Clears first, so that any set in the same cycle wins
    if (!md.serial_enable || (byte_done && fl.release_detected && !match)) begin
      next_fl.release_detected = 1'b0;
    end
    if (!md.serial_enable || rel_cond) begin
      next_fl.command_detected = 1'b0;
    end
    if (ack_end) begin
      next_fl.ack_trigger = 1'b0;
    end

    if (wr.valid) begin
      if (wr.addr == sbcsa_pkg::OFS_CTRL) begin
        if (wr.data[sbcsa_pkg::POS_RELEASE_TRIG]) begin
          next_so = 1'b1;
        end
        if (wr.data[sbcsa_pkg::POS_COMMAND_TRIG]) begin
          next_so = 1'b0;
        end
        if (wr.data[sbcsa_pkg::POS_ACK_TRIG]) begin
          next_fl.ack_trigger = 1'b1;
        end
        next_fl.ack_auto_enable = wr.data[sbcsa_pkg::POS_ACK_AUTO];
        next_fl.busy_signal_enable = wr.data[sbcsa_pkg::POS_BUSY_EN];
      end else if (wr.addr == sbcsa_pkg::OFS_SHIFT) begin
        next_sh = wr.data;
        start = md.serial_enable;
      end else if (wr.addr == sbcsa_pkg::OFS_ADDR) begin
        next_own_addr = wr.data;
      end else if (wr.addr == sbcsa_pkg::OFS_MODE) begin
        next_md.serial_enable = wr.data[sbcsa_pkg::POS_SER_EN];
        next_md.wake_on_address = wr.data[sbcsa_pkg::POS_WAKE];
        next_md.three_wire = wr.data[sbcsa_pkg::POS_THREE_WIRE];
        next_md.line_b = wr.data[sbcsa_pkg::POS_LINE_B];
      end else if (wr.addr == sbcsa_pkg::OFS_STAT) begin
        if (wr.data[sbcsa_pkg::POS_IRQ]) begin
          next_irq = 1'b0;
        end
      end
    end

    if (start) begin
      next_ph = sbcsa_pkg::PH_SHIFT;
      next_cnt = 4'h0;
      next_ack_drv = 1'b0;
      next_ack_sent = 1'b0;
      next_busy_drv = 1'b0;
      next_fl.release_detected = 1'b0;
      next_fl.command_detected = 1'b0;
      next_fl.ack_detected = 1'b0;
    end

    if (rel_cond) begin
      next_fl.release_detected = 1'b1;
    end
    if (cmd_cond) begin
      next_fl.command_detected = 1'b1;
    end
    if (rise && !sda && (ninth || (ph == sbcsa_pkg::PH_DONE && ack_drv))) begin
      next_fl.ack_detected = 1'b1;
    end
    // done flag on ninth rising edge
    if (ninth && (!md.wake_on_address ||
                  (fl.release_detected && md.address_match_flag))) begin
      next_irq = 1'b1;
    end

    // bus line pulled low by latch, ack or busy
    next_oe_a = next_md.serial_enable & ~next_md.three_wire &
                ~next_md.line_b & (~next_so | next_ack_drv | next_busy_drv);
    next_oe_b = next_md.serial_enable & ~next_md.three_wire &
                next_md.line_b & (~next_so | next_ack_drv | next_busy_drv);
  end

  always_ff @(posedge ref_clk_i or negedge rstn) begin
    if (!rstn) begin
      fl <= sbcsa_pkg::FLAGS_RST;
      md <= sbcsa_pkg::MODE_RST;
      ph <= sbcsa_pkg::PH_IDLE;
      cnt <= 4'h0;
      so <= 1'b1;
      ack_drv <= 1'b0;
      ack_sent <= 1'b0;
      busy_drv <= 1'b0;
      irq <= 1'b0;
      oe_a <= 1'b0;
      oe_b <= 1'b0;
    end else begin
      fl <= next_fl;
      md <= next_md;
      ph <= next_ph;
      cnt <= next_cnt;
      so <= next_so;
      ack_drv <= next_ack_drv;
      ack_sent <= next_ack_sent;
      busy_drv <= next_busy_drv;
      irq <= next_irq;
      oe_a <= next_oe_a;
      oe_b <= next_oe_b;
    end
  end

  // data kept across reset, as in standby
  always_ff @(posedge ref_clk_i) begin
    sh <= next_sh;
    own_addr <= next_own_addr;
  end

  assign avs_readdata_o = rdata;
  assign avs_waitrequest_o = wait_q;
  assign serial_output_line_o = so;
  assign bus_data_line_a_o = 1'b0;
  assign bus_data_line_b_o = 1'b0;
  assign bus_data_line_a_oe_o = oe_a;
  assign bus_data_line_b_oe_o = oe_b;

  // ==========================================================
  // Assertions
  logic ctrl_wr;
  assign ctrl_wr = wr.valid && wr.addr == sbcsa_pkg::OFS_CTRL;

  property p_release_trig;
    @(posedge ref_clk_i) disable iff (!rstn)
    ctrl_wr && wr.data[sbcsa_pkg::POS_RELEASE_TRIG] &&
    !wr.data[sbcsa_pkg::POS_COMMAND_TRIG] |=> so;
  endproperty
  a_release_trig: assert property (p_release_trig)
    else $error("release trigger did not set latch");

  property p_command_trig;
    @(posedge ref_clk_i) disable iff (!rstn)
    ctrl_wr && wr.data[sbcsa_pkg::POS_COMMAND_TRIG] |=> !so;
  endproperty
  a_command_trig: assert property (p_command_trig)
    else $error("command trigger did not clear latch");

  property p_release_set;
    @(posedge ref_clk_i) disable iff (!rstn)
    rel_cond |=> fl.release_detected && !fl.command_detected;
  endproperty
  a_release_set: assert property (p_release_set)
    else $error("release not flagged");

  property p_disable_clears;
    @(posedge ref_clk_i) disable iff (!rstn)
    !md.serial_enable |=> !fl.release_detected && !fl.command_detected;
  endproperty
  a_disable_clears: assert property (p_disable_clears)
    else $error("flags survive disable");

  property p_ack_trig_hold;
    @(posedge ref_clk_i) disable iff (!rstn)
    fl.ack_trigger && !ack_end |=> fl.ack_trigger;
  endproperty
  a_ack_trig_hold: assert property (p_ack_trig_hold)
    else $error("ack trigger lost without ack");

  property p_ack_ninth;
    @(posedge ref_clk_i) disable iff (!rstn)
    ph == sbcsa_pkg::PH_ACK9 && fall && md.serial_enable
    |=> ack_drv == $past(fl.ack_auto_enable);
  endproperty
  a_ack_ninth: assert property (p_ack_ninth)
    else $error("ninth clock ack wrong");

  property p_ack_pin;
    @(posedge ref_clk_i) disable iff (!rstn)
    ack_drv && md.serial_enable && !md.three_wire
    |-> (bus_data_line_a_oe_o || bus_data_line_b_oe_o);
  endproperty
  a_ack_pin: assert property (p_ack_pin)
    else $error("ack not driven on line");

  property p_busy_stop;
    @(posedge ref_clk_i) disable iff (!rstn)
    ph == sbcsa_pkg::PH_DONE && fall && !ack_drv &&
    !fl.busy_signal_enable |=> !busy_drv;
  endproperty
  a_busy_stop: assert property (p_busy_stop)
    else $error("busy not stopped at falling edge");

  property p_count_max;
    @(posedge ref_clk_i) disable iff (!rstn)
    cnt <= 4'h8;
  endproperty
  a_count_max: assert property (p_count_max)
    else $error("bit counter beyond eight");

  property p_start;
    @(posedge ref_clk_i) disable iff (!rstn)
    start |=> ph == sbcsa_pkg::PH_SHIFT && cnt == 4'h0 && !fl.ack_detected;
  endproperty
  a_start: assert property (p_start)
    else $error("write did not start transfer");

  property p_irq_nowake;
    @(posedge ref_clk_i) disable iff (!rstn)
    ninth && !md.wake_on_address |=> irq;
  endproperty
  a_irq_nowake: assert property (p_irq_nowake)
    else $error("done flag missing on ninth edge");

  property p_irq_wake;
    @(posedge ref_clk_i) disable iff (!rstn)
    !irq && ninth && md.wake_on_address && !md.address_match_flag
    |=> !irq;
  endproperty
  a_irq_wake: assert property (p_irq_wake)
    else $error("done flag set without address match");

  c_byte: cover property (@(posedge ref_clk_i) disable iff (!rstn) ninth);
  c_ack: cover property (@(posedge ref_clk_i) disable iff (!rstn) ack_end);
  c_rel: cover property (@(posedge ref_clk_i) disable iff (!rstn) rel_cond);
  c_busy: cover property (@(posedge ref_clk_i) disable iff (!rstn)
    busy_drv);

endmodule

/* pkg/sbcsa_pkg.sv */
// Purpose: Shared constants and types of the two-line serial bus block
// Assumes: Avalon-MM slave with 32-bit data, registers in the low byte
// Notes: Offsets are byte addresses of the bus

package sbcsa_pkg;

  // ==========================================================
  // Register map
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_SHIFT = 5'h04;
  localparam logic [4:0] OFS_ADDR = 5'h08;
  localparam logic [4:0] OFS_MODE = 5'h0C;
  localparam logic [4:0] OFS_STAT = 5'h10;

  // ==========================================================
  // Bus control flag bit positions
  localparam int POS_RELEASE_TRIG = 7;
  localparam int POS_COMMAND_TRIG = 6;
  localparam int POS_RELEASE_DET = 5;
  localparam int POS_COMMAND_DET = 4;
  localparam int POS_ACK_TRIG = 3;
  localparam int POS_ACK_AUTO = 2;
  localparam int POS_ACK_DET = 1;
  localparam int POS_BUSY_EN = 0;

  // ==========================================================
  // Mode and status bit positions
  localparam int POS_SER_EN = 7;
  localparam int POS_MATCH = 6;
  localparam int POS_WAKE = 5;
  localparam int POS_THREE_WIRE = 1;
  localparam int POS_LINE_B = 0;
  localparam int POS_IRQ = 0;
  localparam int POS_ACTIVE = 1;

  // ==========================================================
  // Reset values and counts
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [4:0] MODE_RST = 5'h00;
  localparam logic [3:0] LAST_BIT = 4'h7;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SHIFT = 2'b01,
    PH_ACK9 = 2'b10,
    PH_DONE = 2'b11
  } sbcsa_phase_t;

  typedef struct packed {
    logic ack_trigger;
    logic ack_auto_enable;
    logic busy_signal_enable;
    logic release_detected;
    logic command_detected;
    logic ack_detected;
  } sbcsa_flags_t;

  typedef struct packed {
    logic serial_enable;
    logic address_match_flag;
    logic wake_on_address;
    logic three_wire;
    logic line_b;
  } sbcsa_mode_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } sbcsa_wr_t;

endpackage

/* tb/sbcsa_bus_master.sv */
// Purpose: Behavioural far-side master of the two-line serial bus
// Assumes: 80 ns serial clock; the bus line has a pull-up outside
// Notes: Clock stands high between frames; data moves while it is low,
// except for the frame conditions, which need the clock high

`timescale 1ns/1ps

module sbcsa_bus_master (
  // Bus pins
  output logic scl_o,
  output logic pull_o,
  input wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end

  // ==========================================================
  // Frame conditions
  // command, release, command
  // No clock pulse here: the slave would count it as a data bit
  task automatic conds();
    pull_o = 1'b1;
    #20 pull_o = 1'b0;
    #20 pull_o = 1'b1;
    #20;
  endtask

  // ==========================================================
  // Clocks
  // Sampled late in the high phase, as the slave answers through its sync
  task automatic clk1(input logic drv, output logic smp);
    scl_o = 1'b0;
    #20 pull_o = drv;
    #20 scl_o = 1'b1;
    #35 smp = sda_i;
    #5;
  endtask

  // Eight bits MSB first, then the acknowledge clock
  task automatic xfer(input logic [7:0] tx, input logic ack,
                      output logic [7:0] rx, output logic got);
    for (int i = 7; i >= 0; i--) begin
      clk1(!tx[i], rx[i]);
    end
    clk1(ack, got);
  endtask
endmodule

/* tb/test_sbcsa_top.sv */
// Purpose: Self-checking bench of the two-line serial bus block
// Assumes: Far-side master model on line A; line B idles high
// Notes: Expected values queue up; a watcher compares them in order

`timescale 1ns/1ps

module test_sbcsa_top;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic scl, pull, so, a_o, a_oe, b_o, b_oe, got;
  logic [7:0] rx, v, rv, obs;
  wire line_a = (a_oe ? a_o : 1'b1) & !pull;
  wire line_b = b_oe ? b_o : 1'b1;
  int num_errors = 0;
  int compares = 0;
  integer seed = 27;
  logic [7:0] exp_q[$];
  string nam_q[$];
  event obs_ev;

  always #5 ref_clk_i = ~ref_clk_i;

  sbcsa_top sbcsa_top_inst (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .serial_clock_line_i(scl), .serial_input_line_i(line_a),
    .serial_output_line_o(so), .bus_data_line_a_i(line_a),
    .bus_data_line_a_o(a_o), .bus_data_line_a_oe_o(a_oe),
    .bus_data_line_b_i(line_b), .bus_data_line_b_o(b_o),
    .bus_data_line_b_oe_o(b_oe)
  );

  sbcsa_bus_master sbcsa_bus_master_inst (
    .scl_o(scl), .pull_o(pull), .sda_i(line_a)
  );

  // ==========================================================
  // Checking
  task automatic check(input string n, input logic [7:0] s,
                       input logic [7:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic note(input string n, input logic [7:0] e);
    nam_q.push_back(n);
    exp_q.push_back(e);
  endtask

  // The delay keeps two results of one time step apart
  task automatic seen(input logic [7:0] s);
    obs = s;
    -> obs_ev;
    #1;
  endtask

  always @(obs_ev) check(nam_q.pop_front(), obs, exp_q.pop_front());

  task automatic results();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Avalon master
  // Waitrequest is sampled at rising edges; data is taken at that edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 100) begin
      num_errors++;
      results();
    end
    if (!w) seen(avs_readdata_o[7:0]);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input string n, input logic [4:0] a, input logic [7:0] e);
    note(n, e);
    bus(1'b0, a, 8'h00);
  endtask

  task automatic pin(input string n, input logic s, input logic e);
    note(n, {7'h00, e});
    seen({7'h00, s});
  endtask

  task automatic tick(input logic e);
    sbcsa_bus_master_inst.clk1(1'b0, got);
    pin("bus line", got, e);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rd("ctrl", sbcsa_pkg::OFS_CTRL, 8'h00);
    rd("mode", sbcsa_pkg::OFS_MODE, 8'h00);
    rd("stat", sbcsa_pkg::OFS_STAT, 8'h00);
    rd("own addr", sbcsa_pkg::OFS_ADDR, 8'h00);
    rd("unmapped", 5'h14, 8'h00);
    wr(sbcsa_pkg::OFS_CTRL, 8'h40);
    repeat (3) @(posedge ref_clk_i);
    pin("latch", so, 1'b0);
    wr(sbcsa_pkg::OFS_CTRL, 8'h80);
    repeat (3) @(posedge ref_clk_i);
    pin("latch", so, 1'b1);
    rd("ctrl", sbcsa_pkg::OFS_CTRL, 8'h00);
    // Addressed receive with wake on, auto ack and busy
    wr(sbcsa_pkg::OFS_ADDR, 8'h5A);
    wr(sbcsa_pkg::OFS_MODE, 8'hA0);
    wr(sbcsa_pkg::OFS_CTRL, 8'h05);
    wr(sbcsa_pkg::OFS_SHIFT, 8'hFF);
    sbcsa_bus_master_inst.conds();
    rd("ctrl", sbcsa_pkg::OFS_CTRL, 8'h35);
    sbcsa_bus_master_inst.xfer(8'h5A, 1'b0, rx, got);
    pin("ack", got, 1'b0);
    rd("mode", sbcsa_pkg::OFS_MODE, 8'hE0);
    rd("shift", sbcsa_pkg::OFS_SHIFT, 8'h5A);
    tick(1'b0);
    rd("shift", sbcsa_pkg::OFS_SHIFT, 8'h5A);
    rd("stat", sbcsa_pkg::OFS_STAT, 8'h01);
    rd("ctrl", sbcsa_pkg::OFS_CTRL, 8'h37);
    wr(sbcsa_pkg::OFS_CTRL, 8'h04);
    tick(1'b1);
    wr(sbcsa_pkg::OFS_STAT, 8'h01);
    rd("stat", sbcsa_pkg::OFS_STAT, 8'h00);
    // unaddressed byte, then a late ack by trigger
    wr(sbcsa_pkg::OFS_CTRL, 8'h00);
    wr(sbcsa_pkg::OFS_SHIFT, 8'hFF);
    sbcsa_bus_master_inst.conds();
    sbcsa_bus_master_inst.xfer(8'h33, 1'b0, rx, got);
    pin("ack", got, 1'b1);
    rd("mode", sbcsa_pkg::OFS_MODE, 8'hA0);
    rd("stat", sbcsa_pkg::OFS_STAT, 8'h00);
    rd("ctrl", sbcsa_pkg::OFS_CTRL, 8'h10);
    // trigger after transfer, auto ack off
    wr(sbcsa_pkg::OFS_CTRL, 8'h08);
    tick(1'b0);
    tick(1'b1);
    rd("ctrl", sbcsa_pkg::OFS_CTRL, 8'h12);
    // Transmit of a random byte, far side acknowledges
    wr(sbcsa_pkg::OFS_MODE, 8'h80);
    v = 8'($random(seed));
    wr(sbcsa_pkg::OFS_SHIFT, v);
    rd("ctrl", sbcsa_pkg::OFS_CTRL, 8'h00);
    note("tx byte", v);
    sbcsa_bus_master_inst.xfer(8'hFF, 1'b1, rx, got);
    seen(rx);
    tick(1'b1);
    rd("ctrl", sbcsa_pkg::OFS_CTRL, 8'h02);
    rd("stat", sbcsa_pkg::OFS_STAT, 8'h01);
    // Three-wire receive from the serial input, then line B conditions
    wr(sbcsa_pkg::OFS_STAT, 8'h01);
    wr(sbcsa_pkg::OFS_MODE, 8'h82);
    rv = 8'($random(seed));
    wr(sbcsa_pkg::OFS_SHIFT, 8'hFF);
    sbcsa_bus_master_inst.xfer(rv, 1'b0, rx, got);
    rd("shift", sbcsa_pkg::OFS_SHIFT, rv);
    rd("stat", sbcsa_pkg::OFS_STAT, 8'h01);
    wr(sbcsa_pkg::OFS_MODE, 8'h81);
    wr(sbcsa_pkg::OFS_CTRL, 8'h40);
    repeat (3) @(posedge ref_clk_i);
    pin("line b oe", b_oe, 1'b1);
    pin("line a oe", a_oe, 1'b0);
    wr(sbcsa_pkg::OFS_CTRL, 8'h80);
    repeat (3) @(posedge ref_clk_i);
    pin("line b oe", b_oe, 1'b0);
    rd("ctrl", sbcsa_pkg::OFS_CTRL, 8'h20);
    results();
  end
endmodule
